// [spc_defines.svh]
// Offsets, field positions, command codes and timing counts of the controller
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// Software-facing register offsets
`define SPC_OFF_CMD 8'h00
`define SPC_OFF_ZPTR 8'h04
`define SPC_OFF_DATA 8'h08
`define SPC_OFF_STAT 8'h0c
`define SPC_OFF_RBACK 8'h10

// Status register bit positions
`define SPC_STAT_BUSY 0
`define SPC_STAT_REFUSED 1
`define SPC_STAT_TIMEOUT 2
`define SPC_STAT_RWBUSY 3
`define SPC_STAT_BUFDATA 4

// Bits of the device's self-programming control/status register
`define SPC_CSR_ENABLE_BIT 0
`define SPC_CSR_BUSY_FLAG_BIT 6

// Command codes written to the device control register (X bit sent as 0)
`define SPC_CODE_LOAD 8'h01
`define SPC_CODE_ERASE 8'h03
`define SPC_CODE_WRITE 8'h05
`define SPC_CODE_LOCK 8'h09
`define SPC_CODE_REEN 8'h11

// Pointer value used for lock programming and top data bits forced high
`define SPC_LOCK_ZPTR 16'h0001
`define SPC_LOCK_R0_TOP 2'b11

// Timing: longest programming time and the clock period, both in ns
`define SPC_T_PROG_MAX_NS 4500000
`define SPC_CLK_PERIOD_NS 50
`define SPC_PROG_MAX_CYCLES (`SPC_T_PROG_MAX_NS / `SPC_CLK_PERIOD_NS)

// Cycles before the enable bit is trusted as cleared after the store
`define SPC_POLL_SETTLE 8'h02

`endif

// [spc_dev_model.sv]
// Behavioural self-programming unit on the controller's far side
`timescale 1ns/10ps
`include "spc_defines.svh"
module spc_dev_model #(
   parameter int OP_CYCLES = 12,
   parameter logic [7:0] FUSE_LO = 8'h62,
   parameter logic [7:0] FUSE_HI = 8'h99,
   parameter logic [7:0] FUSE_EX = 8'hfd
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ee_busy_in,
   input wire spc_pkg::spc_dev_out_type ctl_in,
   output spc_pkg::spc_dev_in_type ctl_out
);
   logic [7:0] code_q, lock_q, ld_q;
   logic en_q, rwb_q;
   int cnt_q;
   // Live status: enable and area busy flag
   assign ctl_out = '{ctrl_rdata: {1'b0, rwb_q, 5'h00, en_q},
                      load_data: ld_q, eeprom_busy: ee_busy_in};
   // Buffer words accepted in any order, so no order is tracked
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         code_q <= 8'h00;
         lock_q <= 8'hff;
         ld_q <= 8'h00;
         en_q <= 1'b0;
         rwb_q <= 1'b0;
         cnt_q <= 0;
      end else begin
         if (cnt_q > 0) cnt_q <= cnt_q - 1;
         // Enable clear would raise the interrupt; controller polls
         if (cnt_q == 1) en_q <= 1'b0;
         if (ctl_in.ctrl_wr && !ee_busy_in) begin
            code_q <= ctl_in.ctrl_wdata;
            en_q <= 1'b1;
         end
         if (ctl_in.store && code_q == `SPC_CODE_REEN) rwb_q <= 1'b0;
         if (ctl_in.store) begin
            cnt_q <= (code_q == `SPC_CODE_LOAD ||
                      code_q == `SPC_CODE_REEN) ? 1 : OP_CYCLES;
         end
         // Lock programming leaves the flash readable
         if (ctl_in.store && code_q == `SPC_CODE_LOCK) begin
            lock_q <= lock_q & {2'b11, ctl_in.r1r0[5:0]};
         end
         // Core halt is not modelled; only the area busy flag shows
         if (ctl_in.store && (code_q == `SPC_CODE_ERASE ||
                              code_q == `SPC_CODE_WRITE)) rwb_q <= 1'b1;
         // Readback stands one cycle, then the line toggles
         if (ctl_in.load) begin
            en_q <= 1'b0;
            case (ctl_in.zptr[1:0])
               2'b00: ld_q <= FUSE_LO;
               2'b01: ld_q <= lock_q;
               2'b10: ld_q <= FUSE_EX;
               default: ld_q <= FUSE_HI;
            endcase
         end else begin
            ld_q <= ~ld_q;
         end
      end
   end
endmodule

// [spc_flash_ctrl.sv]
// Boot-loader side controller that drives the flash self-programming unit
//
// Summary of operation
// [R1] Page write is refused unless the same page was erased since.
// [R2] Buffer loads go one word per store command, before or after erase.
// [R3] Device accepts buffer loads in any word order.
// [R4] Erase: code X0000011, store within four clocks, page field only.
// [R5] Device keeps no-read-while-write area readable or halts the core.
// [R6] Load: code 00000001, data word and word field, store within four.
// [R7] Buffer clears after page write, re-enable write, or reset.
// [R8] A buffer word already loaded is not loaded again before clearing.
// [R9] An eeprom write during loading discards the loaded words.
// [R10] Write: code X0000101, store within four, only page bits nonzero.
// [R11] Device holds its interrupt while the enable bit reads clear.
// [R12] Device blocks read-while-write area and shows its busy flag.
// [R13] Software re-enables the read-while-write area after programming.
// [R14] Lock programming: code X0001001, store within four, zeros program.
// [R15] Lock programming forces data bits 7 and 6 high, pointer 0x0001.
// [R16] Device keeps flash readable while lock bits are programmed.
// [R17] Device refuses commands while an eeprom write is running.
// [R18] No command is written while the eeprom busy flag is set.
// [R19] Lock byte read: pointer 0x0001, load within three cycles.
// [R20] Lock-set and enable bits clear after read or on a missed window.
// [R21] Pointer 0x0000, 0x0003, 0x0002 read low, high, extended fuses.
// [R22] Programmed fuse and lock bits read zero, unprogrammed one.
// [R23] Enable bit stays set while an operation runs, clear when done.
// [R24] Target address is latched once an operation starts.
// [R25] Each erase, write or lock programming lasts 3.7 ms to 4.5 ms.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "spc_defines.svh"

module spc_flash_ctrl #(
   parameter int WORD_BITS = 7,
   parameter int PROG_MAX_CYCLES = `SPC_PROG_MAX_CYCLES
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output spc_pkg::spc_dev_out_type dev_out,
   input wire spc_pkg::spc_dev_in_type dev_in
);

   localparam int WORDS = 1 << WORD_BITS;
   localparam int PAGE_BITS = 15 - WORD_BITS;
   localparam int CNT_W = $clog2(PROG_MAX_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(PROG_MAX_CYCLES);
   localparam logic [CNT_W-1:0] CNT_SETTLE = CNT_W'(`SPC_POLL_SETTLE);

   // Whole controller state; one copy is computed, one is registered
   typedef struct packed {
      spc_pkg::spc_state_type state;
      spc_pkg::spc_op_type op;
      logic [15:0] zptr;
      logic [15:0] data;
      logic [7:0] rback;
      logic refused;
      logic timeout;
      logic [WORDS-1:0] loaded;
      logic erased_valid;
      logic [PAGE_BITS-1:0] erased_page;
      logic [CNT_W-1:0] cnt;
      logic [31:0] rdata;
      spc_pkg::spc_dev_out_type dev;
   } spc_ctrl_state_type;

   spc_ctrl_state_type s_q;
   spc_ctrl_state_type s_d;

   // Page number field of a byte pointer
   function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] z);
      page_of = z[15:WORD_BITS+1];
   endfunction

   // Word-in-page field of a byte pointer
   function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] z);
      word_of = z[WORD_BITS:1];
   endfunction

   // Pointer with only the page bits kept, all else zero
   function automatic logic [15:0] page_only(input logic [15:0] z);
      page_only = {z[15:WORD_BITS+1], {(WORD_BITS+1){1'b0}}};
   endfunction

   // Next-state logic: register port, command acceptance and sequencer
   always_comb begin
      logic [7:0] code;
      code = `SPC_CODE_LOAD;
      s_d = s_q;
      s_d.dev.ctrl_wr = 1'b0;
      s_d.dev.store = 1'b0;
      s_d.dev.load = 1'b0;
      s_d.rdata = 32'h0000_0000;

      // Software writes to the pointer and data holding registers and to the command register
      if (wr_in && addr_in == `SPC_OFF_ZPTR) begin
         s_d.zptr = wdata_in[15:0];
      end else if (wr_in && addr_in == `SPC_OFF_DATA) begin
         s_d.data = wdata_in[15:0];
      end else if (wr_in && addr_in == `SPC_OFF_CMD) begin
         if (s_q.state != spc_pkg::SPC_ST_IDLE) begin
            s_d.refused = 1'b1;
         end else if (wdata_in[2:0] == spc_pkg::SPC_OP_WRITE &&
                      !(s_q.erased_valid &&
                        s_q.erased_page == page_of(s_q.zptr))) begin
            s_d.refused = 1'b1; // [R1]
         end else if (wdata_in[2:0] == spc_pkg::SPC_OP_LOAD &&
                      s_q.loaded[word_of(s_q.zptr)]) begin
            s_d.refused = 1'b1; // [R8]
         end else if (wdata_in[2:0] > spc_pkg::SPC_OP_REEN) begin
            s_d.refused = 1'b1;
         end else begin
            s_d.refused = 1'b0;
            s_d.timeout = 1'b0;
            s_d.op = spc_pkg::spc_op_type'(wdata_in[2:0]);
            s_d.state = spc_pkg::SPC_ST_EEWAIT;
            // Pins are latched now so software may reuse its registers
            s_d.dev.zptr = s_q.zptr; // [R24]
            s_d.dev.r1r0 = s_q.data;
            case (spc_pkg::spc_op_type'(wdata_in[2:0]))
               spc_pkg::SPC_OP_ERASE: begin
                  s_d.dev.zptr = page_only(s_q.zptr); // [R4]
               end
               spc_pkg::SPC_OP_WRITE: begin
                  s_d.dev.zptr = page_only(s_q.zptr); // [R10]
               end
               spc_pkg::SPC_OP_LOCKPRG: begin
                  s_d.dev.zptr = `SPC_LOCK_ZPTR; // [R15]
                  s_d.dev.r1r0[7:6] = `SPC_LOCK_R0_TOP; // [R15]
               end
               default: begin
               end
            endcase
         end
      end

      // Register reads answer one cycle later
      if (rd_in) begin
         if (addr_in == `SPC_OFF_ZPTR) begin
            s_d.rdata = {16'h0000, s_q.zptr};
         end else if (addr_in == `SPC_OFF_DATA) begin
            s_d.rdata = {16'h0000, s_q.data};
         end else if (addr_in == `SPC_OFF_STAT) begin
            s_d.rdata[`SPC_STAT_BUSY] = s_q.state != spc_pkg::SPC_ST_IDLE;
            s_d.rdata[`SPC_STAT_REFUSED] = s_q.refused;
            s_d.rdata[`SPC_STAT_TIMEOUT] = s_q.timeout;
            s_d.rdata[`SPC_STAT_RWBUSY] =
               dev_in.ctrl_rdata[`SPC_CSR_BUSY_FLAG_BIT]; // [R12]
            s_d.rdata[`SPC_STAT_BUFDATA] = |s_q.loaded;
         end else if (addr_in == `SPC_OFF_RBACK) begin
            s_d.rdata = {24'h00_0000, s_q.rback};
         end
      end

      // Control code chosen by the pending operation
      case (s_q.op)
         spc_pkg::SPC_OP_LOAD: code = `SPC_CODE_LOAD; // [R6]
         spc_pkg::SPC_OP_ERASE: code = `SPC_CODE_ERASE; // [R4]
         spc_pkg::SPC_OP_WRITE: code = `SPC_CODE_WRITE; // [R10]
         spc_pkg::SPC_OP_LOCKPRG: code = `SPC_CODE_LOCK; // [R14]
         spc_pkg::SPC_OP_FUSERD: code = `SPC_CODE_LOCK; // [R19] [R21]
         spc_pkg::SPC_OP_REEN: code = `SPC_CODE_REEN; // [R13]
         default: code = `SPC_CODE_LOAD;
      endcase

      // Sequencer
      case (s_q.state)
         spc_pkg::SPC_ST_IDLE: begin
         end
         spc_pkg::SPC_ST_EEWAIT: begin
            // Device would drop the command during an eeprom write
            if (!dev_in.eeprom_busy) begin // [R18] [R17]
               s_d.dev.ctrl_wr = 1'b1;
               s_d.dev.ctrl_wdata = code;
               s_d.state = spc_pkg::SPC_ST_ISSUE;
            end
         end
         spc_pkg::SPC_ST_ISSUE: begin
            // Instruction goes out one clock after the control write
            s_d.cnt = '0;
            if (s_q.op == spc_pkg::SPC_OP_FUSERD) begin
               s_d.dev.load = 1'b1; // [R19] [R21]
               s_d.state = spc_pkg::SPC_ST_LDWAIT;
            end else begin
               s_d.dev.store = 1'b1; // [R4] [R6] [R10] [R14]
               s_d.state = spc_pkg::SPC_ST_POLL;
               if (s_q.op == spc_pkg::SPC_OP_LOAD) begin
                  s_d.loaded[word_of(s_q.dev.zptr)] = 1'b1; // [R2] [R3]
               end else if (s_q.op == spc_pkg::SPC_OP_ERASE) begin
                  s_d.erased_valid = 1'b1; // [R1]
                  s_d.erased_page = page_of(s_q.dev.zptr);
               end else if (s_q.op == spc_pkg::SPC_OP_WRITE) begin
                  s_d.erased_valid = 1'b0; // [R1]
               end
            end
         end
         spc_pkg::SPC_ST_LDWAIT: begin
            s_d.state = spc_pkg::SPC_ST_CAPT;
         end
         spc_pkg::SPC_ST_CAPT: begin
            // Byte is stored as read: programmed bits show as zero
            s_d.rback = dev_in.load_data; // [R22]
            s_d.cnt = '0;
            s_d.state = spc_pkg::SPC_ST_POLL; // [R20]
         end
         spc_pkg::SPC_ST_POLL: begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
            // Enable bit is held by the device until it finishes
            if (s_q.cnt >= CNT_SETTLE &&
                !dev_in.ctrl_rdata[`SPC_CSR_ENABLE_BIT]) begin // [R23]
               s_d.state = spc_pkg::SPC_ST_IDLE;
               if (s_q.op == spc_pkg::SPC_OP_WRITE ||
                   s_q.op == spc_pkg::SPC_OP_REEN) begin
                  s_d.loaded = '0; // [R7]
               end
            end else if (s_q.cnt >= CNT_MAX) begin
               // Beyond the longest programming time: give up
               s_d.timeout = 1'b1; // [R25]
               s_d.state = spc_pkg::SPC_ST_IDLE;
            end
         end
         default: begin
            s_d.state = spc_pkg::SPC_ST_IDLE;
         end
      endcase

      // Device loses buffered words when the eeprom is written
      if (dev_in.eeprom_busy) begin
         s_d.loaded = '0; // [R9]
      end
   end

   // State register; reset also clears the buffer shadow
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_q <= '0; // [R7]
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_out = s_q.rdata;
   assign dev_out = s_q.dev;

endmodule

// [spc_flash_ctrl_checker.sv]
// Assertions on the controller's device pins and bus
`timescale 1ns/10ps
`include "spc_defines.svh"
module spc_flash_ctrl_checker #(
   parameter int WORD_BITS = 7,
   parameter int PROG_MAX_CYCLES = 50
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire spc_pkg::spc_dev_out_type dev_out,
   input wire spc_pkg::spc_dev_in_type dev_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // Timed sequence: the instruction must land inside the open window
   AST_INSTR_FOLLOWS: assert property (
      dev_out.ctrl_wr |=> dev_out.store || dev_out.load)
      else $error("no instruction after control write");
   AST_EE_IDLE: assert property (
      dev_out.ctrl_wr |-> !$past(dev_in.eeprom_busy))
      else $error("control write while eeprom busy");
   AST_STORE_PULSE: assert property (
      dev_out.store |=> !dev_out.store)
      else $error("store longer than one cycle");
   AST_PAGE_ONLY: assert property (
      dev_out.store && (dev_out.ctrl_wdata == `SPC_CODE_ERASE ||
      dev_out.ctrl_wdata == `SPC_CODE_WRITE) |->
      dev_out.zptr[WORD_BITS:0] == '0)
      else $error("word bits set on erase or write");
   AST_LOCK_ARGS: assert property (
      dev_out.store && dev_out.ctrl_wdata == `SPC_CODE_LOCK |->
      dev_out.zptr == 16'h0001 && dev_out.r1r0[7:6] == 2'b11)
      else $error("lock programming arguments wrong");
   AST_LOAD_READ: assert property (
      dev_out.load |->
      $past(dev_out.ctrl_wr) && dev_out.ctrl_wdata == `SPC_CODE_LOCK)
      else $error("load outside lock read window");
   AST_ARGS_HELD: assert property (
      dev_out.ctrl_wr |=> $stable(dev_out.zptr) && $stable(dev_out.r1r0))
      else $error("pointer moved inside timed sequence");
   AST_CODE_HELD: assert property (
      dev_out.store |->
      $past(dev_out.ctrl_wr) && $stable(dev_out.ctrl_wdata))
      else $error("store without fresh control write");
   AST_ONE_AT_A_TIME: assert property (
      dev_out.ctrl_wr |-> !dev_in.ctrl_rdata[0])
      else $error("command issued while device busy");
   // Read data stand only in the cycle after a read strobe
   AST_RDATA_IDLE: assert property (
      !$past(rd_in) |-> rdata_out == 32'h0000_0000)
      else $error("read data outside answer cycle");
endmodule
bind spc_flash_ctrl spc_flash_ctrl_checker #(
   .WORD_BITS(WORD_BITS),
   .PROG_MAX_CYCLES(PROG_MAX_CYCLES)
) chk_u (
   .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .dev_out(dev_out), .dev_in(dev_in)
);

// [spc_pkg.sv]
// Types shared by the self-programming flash controller
package spc_pkg;

   // Operation requested by software through the command register
   typedef enum logic [2:0] {
      SPC_OP_LOAD = 3'b000,
      SPC_OP_ERASE = 3'b001,
      SPC_OP_WRITE = 3'b010,
      SPC_OP_LOCKPRG = 3'b011,
      SPC_OP_FUSERD = 3'b100,
      SPC_OP_REEN = 3'b101
   } spc_op_type;

   // Sequencer states
   typedef enum logic [2:0] {
      SPC_ST_IDLE = 3'b000,
      SPC_ST_EEWAIT = 3'b001,
      SPC_ST_ISSUE = 3'b010,
      SPC_ST_LDWAIT = 3'b011,
      SPC_ST_CAPT = 3'b100,
      SPC_ST_POLL = 3'b101
   } spc_state_type;

   // Signals driven toward the device
   typedef struct packed {
      logic ctrl_wr;
      logic [7:0] ctrl_wdata;
      logic store;
      logic load;
      logic [15:0] zptr;
      logic [15:0] r1r0;
   } spc_dev_out_type;

   // Signals coming back from the device
   typedef struct packed {
      logic [7:0] ctrl_rdata;
      logic [7:0] load_data;
      logic eeprom_busy;
   } spc_dev_in_type;

endpackage

// [tb.sv]
// Self-checking bench for the flash self-programming controller
`timescale 1ns/10ps
`include "spc_defines.svh"
module tb;
   logic clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, ee_busy = 0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0, rdata_out, rd_v, seen;
   logic [7:0] exp_b [4] = '{8'h62, 8'hf3, 8'hfd, 8'h99};
   spc_pkg::spc_dev_out_type dev_o;
   spc_pkg::spc_dev_in_type dev_i;
   int num_errors = 0, comparisons = 0, cycles = 0;
   spc_flash_ctrl #(.PROG_MAX_CYCLES(50)) dut_u (.clk_in(clk_in),
      .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .dev_out(dev_o), .dev_in(dev_i));
   spc_dev_model dev_u (.clk_in(clk_in), .resetn_in(resetn_in),
      .ee_busy_in(ee_busy), .ctl_in(dev_o), .ctl_out(dev_i));
   initial forever #25 clk_in = ~clk_in;
   // Pointer and data as the device takes them; also cuts a hang short
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (dev_o.store) seen <= {dev_o.zptr, dev_o.r1r0};
      if (cycles > 20000) begin
         num_errors = num_errors + 1;
         results();
      end
   end
   task automatic results();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, s);
      comparisons = comparisons + 1;
      if (s !== e) begin
         num_errors = num_errors + 1;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 rd_v = rdata_out;
   endtask
   // Poll status until idle; the last status read is left in rd_v
   task automatic idle();
      for (int i = 0; i < 100; i++) begin
         rd(`SPC_OFF_STAT);
         if (rd_v[0] === 1'b0) break;
      end
   endtask
   task automatic cmd(input logic [15:0] z, input logic [31:0] op,
                      input logic [31:0] st, input string n);
      wr(`SPC_OFF_ZPTR, {16'h0, z});
      wr(`SPC_OFF_CMD, op);
      idle();
      chk(n, st, rd_v);
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      wr(8'h14, 32'hffffffff);
      rd(8'h14);
      chk("unmapped", 32'h0, rd_v);
      wr(`SPC_OFF_DATA, 32'h0000beef);
      cmd(16'h0a06, 0, 32'h10, "load_stat");
      chk("load_args", 32'h0006beef, seen & 32'h00feffff);
      cmd(16'h0a00, 2, 32'h12, "write_unerased");
      cmd(16'h0a02, 0, 32'h10, "load_lower_word");
      cmd(16'h0a02, 0, 32'h12, "load_twice");
      cmd(16'h0a5b, 1, 32'h18, "erase_stat");
      chk("erase_page", 32'h0a00, {16'h0, seen[31:16]});
      cmd(16'h0a00, 2, 32'h08, "write_stat");
      cmd(16'h0a00, 5, 32'h00, "reenable");
      cmd(16'h0a00, 6, 32'h02, "bad_op");
      ee_busy <= 1'b1;
      wr(`SPC_OFF_CMD, 0);
      repeat (6) rd(`SPC_OFF_STAT);
      chk("ee_hold", 32'h01, rd_v);
      ee_busy <= 1'b0;
      idle();
      chk("ee_done", 32'h10, rd_v);
      ee_busy <= 1'b1;
      @(posedge clk_in);
      ee_busy <= 1'b0;
      rd(`SPC_OFF_STAT);
      chk("ee_discard", 32'h00, rd_v);
      wr(`SPC_OFF_DATA, 32'h000000f3);
      cmd(16'h0000, 3, 32'h00, "lock_prog");
      for (int i = 0; i < 4; i++) begin
         cmd(i[15:0], 4, 32'h00, "fuse_stat");
         rd(`SPC_OFF_RBACK);
         chk("fuse_byte", {24'h0, exp_b[i]}, rd_v);
      end
      results();
   end
endmodule
